/* File: src/an_np_pkg.sv */
package an_np_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int          PAGE_W    = 16;
  localparam int          CODE_W    = 11;
  localparam int          BUS_W     = 32;
  localparam int          ADR_W     = 8;
  localparam int          IDX_W     = 6;

  // ****************************************************
  // register indices, byte address is four times these
  // ****************************************************
  localparam logic [5:0]  IDX_EXP   = 6'h06;
  localparam logic [5:0]  IDX_TX    = 6'h07;
  localparam logic [5:0]  IDX_RX    = 6'h08;

  // ****************************************************
  // expansion status fields
  // ****************************************************
  localparam int          EXP_RSV_HI   = 15;
  localparam int          EXP_RSV_LO   = 7;
  localparam int          LOC_ABLE_BIT = 6;
  localparam int          STOR_LOC_BIT = 5;
  localparam int          PDF_BIT      = 4;
  localparam int          LPNP_BIT     = 3;
  localparam int          NPABLE_BIT   = 2;
  localparam int          PRX_BIT      = 1;
  localparam int          LPAN_BIT     = 0;

  // ****************************************************
  // next page fields
  // ****************************************************
  localparam int          NP_BIT    = 15;
  localparam int          ACK_BIT   = 14;
  localparam int          MP_BIT    = 13;
  localparam int          COMPLY_ACKNOWLEDGE_BIT  = 12;
  localparam int          TOG_BIT   = 11;
  localparam int          CODE_HI   = 10;

  // ****************************************************
  // reset values and transmit write mask
  // ****************************************************
  localparam logic        LOC_ABLE_RST = 1'b1;
  localparam logic        STOR_LOC_RST = 1'b1;
  localparam logic        LOCAL_NEXT_PAGE_CAPABLE_RST  = 1'b1;
  localparam logic [15:0] TX_RST       = 16'h2001;
  localparam logic [15:0] RX_RST       = 16'h2001;
  localparam logic [15:0] TX_WR_MASK   = 16'hb7ff;

endpackage

/* File: src/autoneg_next_page_regs.sv */
`timescale 1ns/100ps
module autoneg_next_page_regs (
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [an_np_pkg::ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [an_np_pkg::BUS_W-1:0]      wb_dat_i,
  output logic      [an_np_pkg::BUS_W-1:0]      wb_dat_o,
  output logic                                  wb_ack_o,
  input  wire logic                             pageRxStrobe,
  input  wire logic [an_np_pkg::PAGE_W-1:0]     rxWord,
  input  wire logic                             pageExchanged,
  input  wire logic                             localAck,
  input  wire logic                             parallelFault,
  input  wire logic                             partnerNextPageCapable,
  input  wire logic                             partnerAutonegCapable,
  output logic      [an_np_pkg::PAGE_W-1:0]     txPage,
  output logic                                  txMessagePage,
  output logic                                  txPageWritten
);
  import an_np_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic              ack;
    logic [BUS_W-1:0]  dat;
    logic              pageReceived;
    logic              toggle;
    logic              ackTx;
    logic              npAble;
    logic              written;
    logic [PAGE_W-1:0] txReg;
    logic [PAGE_W-1:0] rxReg;
  } state_type;

  state_type st;
  state_type next_st;

  logic              req;
  logic              rdReq;
  logic              wrReq;
  logic [PAGE_W-1:0] wrMask;
  logic [PAGE_W-1:0] expWord;
  logic [PAGE_W-1:0] txWord;

  // ****************************************************
  // decode
  // ****************************************************
  function automatic logic hits(input logic [ADR_W-1:0] adr,
                                input logic [IDX_W-1:0] idx);
    hits = (adr[ADR_W-1:2] == idx);
  endfunction

  assign req    = wb_cyc_i & wb_stb_i & ~st.ack;
  assign rdReq  = req & ~wb_we_i;
  assign wrReq  = req & wb_we_i;
  // byte lanes beyond the low two carry nothing
  assign wrMask = TX_WR_MASK & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ****************************************************
  // read views
  // ****************************************************
  always_comb begin
    expWord                            = '0;
    expWord[LOC_ABLE_BIT]              = LOC_ABLE_RST;
    expWord[STOR_LOC_BIT]              = STOR_LOC_RST;
    expWord[PDF_BIT]                   = parallelFault;
    expWord[LPNP_BIT]                  = partnerNextPageCapable;
    expWord[NPABLE_BIT]                = st.npAble;
    expWord[PRX_BIT]                   = st.pageReceived;
    expWord[LPAN_BIT]                  = partnerAutonegCapable;
  end

  always_comb begin
    txWord           = st.txReg;
    txWord[ACK_BIT]  = st.ackTx;
    txWord[TOG_BIT]  = st.toggle;
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_st         = st;
    next_st.ack     = req;
    next_st.written = 1'b0;
    // local acknowledge is tracked every cycle, not only on pages
    next_st.ackTx   = localAck;
    if (rdReq) begin
      if (hits(wb_adr_i, IDX_EXP)) begin
        next_st.dat = {16'h0000, expWord};
      end else if (hits(wb_adr_i, IDX_TX)) begin
        next_st.dat = {16'h0000, txWord};
      end else if (hits(wb_adr_i, IDX_RX)) begin
        next_st.dat = {16'h0000, st.rxReg};
      end else begin
        next_st.dat = '0;
      end
    end
    if (wrReq && hits(wb_adr_i, IDX_TX)) begin
      next_st.txReg   = (st.txReg & ~wrMask) | (wb_dat_i[PAGE_W-1:0] & wrMask);
      next_st.written = 1'b1;
    end
    // a read clears the flag but a page arriving alongside wins
    if (rdReq && hits(wb_adr_i, IDX_EXP)) begin
      next_st.pageReceived = 1'b0;
    end
    if (pageRxStrobe) begin
      next_st.pageReceived = 1'b1;
      next_st.rxReg        = rxWord;
    end
    if (pageExchanged) begin
      next_st.toggle = ~st.toggle;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st              <= '0;
      st.npAble       <= LOCAL_NEXT_PAGE_CAPABLE_RST;
      st.txReg        <= TX_RST;
      st.rxReg        <= RX_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign wb_ack_o      = st.ack;
  assign wb_dat_o      = st.dat;
  assign txPage        = txWord;
  // code is a message code when set, else application defined
  assign txMessagePage = st.txReg[MP_BIT];
  assign txPageWritten = st.written;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic expRd;
  logic txWrFull;
  assign expRd    = rdReq & hits(wb_adr_i, IDX_EXP);
  assign txWrFull = wrReq & hits(wb_adr_i, IDX_TX) & (wb_sel_i[1:0] == 2'b11);
  logic txRd;
  logic rxRd;
  logic rxWr;
  logic expWr;
  logic txWrAny;
  logic unmRd;
  assign txRd    = rdReq & hits(wb_adr_i, IDX_TX);
  assign rxRd    = rdReq & hits(wb_adr_i, IDX_RX);
  assign rxWr    = wrReq & hits(wb_adr_i, IDX_RX);
  assign expWr   = wrReq & hits(wb_adr_i, IDX_EXP);
  assign txWrAny = wrReq & hits(wb_adr_i, IDX_TX);
  assign unmRd   = rdReq & ~hits(wb_adr_i, IDX_EXP) & ~hits(wb_adr_i, IDX_TX)
                   & ~hits(wb_adr_i, IDX_RX);

  property p_exp_fixed;
    expRd |=> (wb_ack_o && wb_dat_o[BUS_W-1:EXP_RSV_LO] == '0
               && wb_dat_o[LOC_ABLE_BIT] && wb_dat_o[STOR_LOC_BIT]
               && wb_dat_o[NPABLE_BIT]);
  endproperty
  a_exp_fixed: assert property (p_exp_fixed) else $error("expansion fixed bits wrong");

  property p_exp_live;
    expRd |=> (wb_dat_o[PDF_BIT] == $past(parallelFault)
               && wb_dat_o[LPNP_BIT] == $past(partnerNextPageCapable)
               && wb_dat_o[LPAN_BIT] == $past(partnerAutonegCapable));
  endproperty
  a_exp_live: assert property (p_exp_live) else $error("expansion status bits stale");

  property p_loc;
    expRd |=> (wb_dat_o[6:5] == 2'b11);
  endproperty
  a_loc: assert property (p_loc) else $error("storage location bits wrong");

  property p_prx_set;
    pageRxStrobe |=> st.pageReceived ##1 (st.pageReceived || $past(expRd));
  endproperty
  a_prx_set: assert property (p_prx_set) else $error("page flag not set");

  property p_prx_clr;
    (expRd && !pageRxStrobe) |=> (!st.pageReceived && wb_dat_o[PRX_BIT] == $past(st.pageReceived));
  endproperty
  a_prx_clr: assert property (p_prx_clr) else $error("page flag not cleared");

  property p_rx_load;
    pageRxStrobe |=> (st.rxReg == $past(rxWord));
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("receive page not loaded");

  property p_toggle;
    pageExchanged |=> (txPage[TOG_BIT] == !$past(txPage[TOG_BIT]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert");

  property p_tx_ack;
    ##1 (txPage[ACK_BIT] == $past(localAck));
  endproperty
  a_tx_ack: assert property (p_tx_ack) else $error("transmit ack not tracking");

  property p_tx_wr;
    txWrFull |=> (txPage[NP_BIT] == $past(wb_dat_i[NP_BIT])
                  && txPage[MP_BIT] == $past(wb_dat_i[MP_BIT])
                  && txPage[COMPLY_ACKNOWLEDGE_BIT] == $past(wb_dat_i[COMPLY_ACKNOWLEDGE_BIT])
                  && txPage[CODE_HI:0] == $past(wb_dat_i[CODE_HI:0])
                  && txPageWritten);
  endproperty
  a_tx_wr: assert property (p_tx_wr) else $error("transmit write lost");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");

  // ****************************************************
  // bus and field checks
  // ****************************************************

  property p_rd_upper;
    rdReq |=> (wb_dat_o[BUS_W-1:PAGE_W] == '0);
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");

  property p_dat_hold;
    !rdReq |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");

  property p_unmapped;
    unmRd |=> (wb_dat_o == '0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_ack_answer;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  property p_ack_cause;
    wb_ack_o |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

  property p_loc_able;
    expRd |=> (wb_dat_o[LOC_ABLE_BIT] == LOC_ABLE_RST);
  endproperty
  a_loc_able: assert property (p_loc_able) else $error("location able bit wrong");

  property p_local_next_page_capable;
    expRd |=> wb_dat_o[NPABLE_BIT];
  endproperty
  a_local_next_page_capable: assert property (p_local_next_page_capable) else $error("next page able reads zero");

  property p_np_const;
    st.npAble;
  endproperty
  a_np_const: assert property (p_np_const) else $error("next page able lost");

  property p_lpnp;
    expRd |=> (wb_dat_o[LPNP_BIT] == $past(partnerNextPageCapable));
  endproperty
  a_lpnp: assert property (p_lpnp) else $error("partner next page bit wrong");

  property p_lpan;
    expRd |=> (wb_dat_o[LPAN_BIT] == $past(partnerAutonegCapable));
  endproperty
  a_lpan: assert property (p_lpan) else $error("partner autoneg bit wrong");

  property p_exp_wr_ign;
    expWr |=> (st.txReg == $past(st.txReg)
               && $stable(wb_dat_o));
  endproperty
  a_exp_wr_ign: assert property (p_exp_wr_ign) else $error("status write had effect");

  property p_set_wins;
    (pageRxStrobe && expRd) |=> st.pageReceived;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat page arrival");

  property p_prx_hold;
    (!pageRxStrobe && !expRd) |=> $stable(st.pageReceived);
  endproperty
  a_prx_hold: assert property (p_prx_hold) else $error("page flag moved");

  property p_rx_hold;
    !pageRxStrobe |=> $stable(st.rxReg);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive page moved");

  property p_rx_ro;
    (rxWr && !pageRxStrobe) |=> $stable(st.rxReg);
  endproperty
  a_rx_ro: assert property (p_rx_ro) else $error("receive page written");

  property p_rx_np;
    rxRd |=> (wb_dat_o[NP_BIT] == $past(st.rxReg[NP_BIT]));
  endproperty
  a_rx_np: assert property (p_rx_np) else $error("partner more pages wrong");

  property p_rx_ack;
    rxRd |=> (wb_dat_o[ACK_BIT] == $past(st.rxReg[ACK_BIT]));
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("partner ack wrong");

  property p_rx_mp;
    rxRd |=> (wb_dat_o[MP_BIT] == $past(st.rxReg[MP_BIT]));
  endproperty
  a_rx_mp: assert property (p_rx_mp) else $error("partner message flag wrong");

  property p_rx_comply_acknowledge;
    rxRd |=> (wb_dat_o[COMPLY_ACKNOWLEDGE_BIT] == $past(st.rxReg[COMPLY_ACKNOWLEDGE_BIT]));
  endproperty
  a_rx_comply_acknowledge: assert property (p_rx_comply_acknowledge) else $error("partner comply wrong");

  property p_tx_read;
    txRd |=> (wb_dat_o[PAGE_W-1:0] == $past(txPage));
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("transmit readback wrong");

  property p_tx_ro_bits;
    txWrFull |=> (txPage[ACK_BIT] == $past(localAck)
                  && txPage[TOG_BIT] == ($past(txPage[TOG_BIT]) ^ $past(pageExchanged)));
  endproperty
  a_tx_ro_bits: assert property (p_tx_ro_bits) else $error("read only bits written");

  property p_tx_keep;
    !txWrAny |=> ($stable(txPage[NP_BIT]) && $stable(txPage[MP_BIT])
                  && $stable(txPage[COMPLY_ACKNOWLEDGE_BIT])
                  && $stable(txPage[CODE_HI:0]));
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("transmit page moved");

  property p_mp_out;
    txMessagePage == txPage[MP_BIT];
  endproperty
  a_mp_out: assert property (p_mp_out) else $error("message page out wrong");

  property p_txmp_wr;
    txWrFull |=> (txMessagePage == $past(wb_dat_i[MP_BIT]));
  endproperty
  a_txmp_wr: assert property (p_txmp_wr) else $error("message flag write lost");

  property p_toggle_hold;
    !pageExchanged |=> $stable(txPage[TOG_BIT]);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved alone");

  property p_written;
    txPageWritten |-> $past(txWrAny);
  endproperty
  a_written: assert property (p_written) else $error("spurious write pulse");

  c_page_read: cover property (pageRxStrobe ##[1:20] expRd);
  c_tx_write: cover property (txWrFull ##1 txPageWritten);
  c_set_clear: cover property (pageRxStrobe && expRd);
  c_exchange_ack: cover property (pageExchanged && localAck);
  c_back_to_back: cover property (pageRxStrobe ##1 pageRxStrobe);

endmodule

/* File: dv/link_partner_model.sv */
`timescale 1ns/100ps
module link_partner_model (
  input  wire logic        clk,
  output logic             pageRxStrobe,
  output logic [15:0]      rxWord,
  output logic             pageExchanged
);
  // ****************************************************
  // far side: pages and exchanges on demand
  // ****************************************************
  initial begin
    pageRxStrobe = 1'h0;
    rxWord = 16'h0000;
    pageExchanged = 1'h0;
  end

  task automatic send_pages(input logic [15:0] a, input logic [15:0] b);
    pageRxStrobe <= 1'h1;
    rxWord <= a;
    @(posedge clk);
    rxWord <= b;
    @(posedge clk);
    pageRxStrobe <= 1'h0;
    // stale word must not look like a valid page
    rxWord <= ~b;
  endtask

  task automatic exchange;
    pageExchanged <= 1'h1;
    @(posedge clk);
    pageExchanged <= 1'h0;
  endtask
endmodule

/* File: dv/autoneg_next_page_regs_tb.sv */
`timescale 1ns/100ps
module autoneg_next_page_regs_tb;
  import an_np_pkg::*;
  // ****************************************************
  // signals
  // ****************************************************
  logic              clk, rst, cyc, stb, we, ack, pFault, pNp, pAn, lAck, wrPulse;
  logic              pStb, pEx, txMp, txWr;
  logic [ADR_W-1:0]  adr;
  logic [3:0]        sel;
  logic [BUS_W-1:0]  wdat, rdat;
  logic [PAGE_W-1:0] rxW, txPage, rd;
  int                errTotal = 0;
  int                nCompared = 0;
  int                cycles = 0;

  autoneg_next_page_regs DUT (.clk(clk), .sys_rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pageRxStrobe(pStb), .rxWord(rxW), .pageExchanged(pEx),
    .localAck(lAck), .parallelFault(pFault), .partnerNextPageCapable(pNp),
    .partnerAutonegCapable(pAn), .txPage(txPage), .txMessagePage(txMp),
    .txPageWritten(txWr));
  link_partner_model LP (.clk(clk), .pageRxStrobe(pStb), .rxWord(rxW), .pageExchanged(pEx));

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic wb(input logic w, input logic [5:0] idx, input logic [15:0] d,
                    output logic [15:0] q);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    // ack and data are read at the edge, before it updates them
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat[15:0];
    wrPulse = txWr;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    wb(1'h0, IDX_EXP, 16'h0000, rd);
    chk(rd, 16'h0064, "status reset");
    wb(1'h0, IDX_TX, 16'h0000, rd);
    chk(rd, 16'h2001, "tx reset");
    wb(1'h0, IDX_RX, 16'h0000, rd);
    chk(rd, 16'h2001, "rx reset");
    wb(1'h0, 6'h3f, 16'h0000, rd);
    chk(rd, 16'h0000, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_status;
    logic [15:0] st [4] = '{16'h0074, 16'h006c, 16'h0065, 16'h0064};
    wb(1'h1, IDX_EXP, 16'hffff, rd);
    for (int k = 0; k < 4; k++) begin
      {pFault, pNp, pAn} <= 3'h4 >> k;
      @(posedge clk);
      wb(1'h0, IDX_EXP, 16'h0000, rd);
      chk(rd, st[k], "status bits");
    end
    $display("test status done");
  endtask

  task automatic t_page;
    LP.send_pages(16'h6555, 16'h9aaa);
    wb(1'h1, IDX_RX, 16'h0000, rd);
    wb(1'h0, IDX_EXP, 16'h0000, rd);
    chk(rd, 16'h0066, "flag set");
    wb(1'h0, IDX_EXP, 16'h0000, rd);
    chk(rd, 16'h0064, "flag cleared");
    wb(1'h0, IDX_RX, 16'h0000, rd);
    chk(rd, 16'h9aaa, "rx page");
    $display("test page done");
  endtask

  task automatic t_tx;
    wb(1'h1, IDX_TX, 16'hffff, rd);
    chk({15'h0000, wrPulse}, 16'h0001, "write pulse");
    chk(txPage, 16'hb7ff, "tx ones");
    chk({15'h0000, txMp}, 16'h0001, "mp set");
    wb(1'h1, IDX_TX, 16'h0000, rd);
    chk(txPage, 16'h0000, "tx zero");
    chk({15'h0000, txMp}, 16'h0000, "mp clear");
    lAck <= 1'h1;
    LP.exchange();
    @(negedge clk);
    chk(txPage, 16'h4800, "ack toggle");
    wb(1'h0, IDX_TX, 16'h0000, rd);
    chk(rd, 16'h4800, "tx read");
    lAck <= 1'h0;
    LP.exchange();
    @(negedge clk);
    chk(txPage, 16'h0000, "toggle back");
    $display("test transmit done");
  endtask

  task automatic t_midreset;
    LP.send_pages(16'h1234, 16'h1234);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(txPage, 16'h2001, "tx after reset");
    wb(1'h0, IDX_EXP, 16'h0000, rd);
    chk(rd, 16'h0064, "flag after reset");
    wb(1'h0, IDX_RX, 16'h0000, rd);
    chk(rd, 16'h2001, "rx after reset");
    $display("test midreset done");
  endtask

  // ****************************************************
  // run
  // ****************************************************
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // a hang counts as a failure, not a silent stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errTotal++;
      give_verdict();
    end
  end

  initial begin
    {rst, cyc, stb, we, pFault, pNp, pAn, lAck} = 8'h80;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h00000000;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_status();
    t_page();
    @(posedge clk);
    t_tx();
    t_midreset();
    give_verdict();
  end
endmodule
